// file: rtl/rtcsp_dev.sv
`timescale 1ns/100ps
module rtcsp_dev
  import rtcsp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // link
  rtcsp_if.dev            link,
  // register store side
  output logic [3:0]      reg_addr_o,
  input  wire logic [7:0] reg_rdata_i,
  output logic            wr_valid_o,
  input  wire logic       wr_ready_i,
  output logic [7:0]      wr_data_o,
  output logic [3:0]      wr_addr_o,
  output logic            carry_hold_o
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]   ce_s;
    logic [2:0]   ck_s;
    logic [2:0]   si_s;
    logic         ce;
    logic         ck;
    logic         pol;
    rtcsp_phase_e ph;
    logic [3:0]   ptr;
    logic [3:0]   fmt;
    logic [2:0]   cnt;
    logic [7:0]   sh;
    logic [7:0]   tx;
    logic         so;
    logic [1:0]   nb;
    logic [11:0]  b0;
    logic [11:0]  b1;
  } rtcsp_dev_s;

  rtcsp_dev_s  q;
  rtcsp_dev_s  d;

  // ------------------------------------------------------------------
  // decoded strobes
  // ------------------------------------------------------------------
  logic        ce_nx;
  logic        ck_nx;
  logic        si_nx;
  logic        ce_rise;
  logic        ce_fall;
  logic        ck_edge;
  logic        smp;
  logic        drv;
  logic        rd;
  logic        burst;
  logic        byte_end;
  logic        push;
  logic        pop;
  logic        push_ok;
  logic [7:0]  byte_in;
  logic [11:0] entry;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d        = q;

    // ----------------------------------------------------------------
    // pin synchronisers, a ce or sclk change counts once two stages agree
    // ----------------------------------------------------------------
    d.ce_s   = {q.ce_s[1:0], link.ce};
    d.ck_s   = {q.ck_s[1:0], link.sclk};
    d.si_s   = {q.si_s[1:0], link.si};
    ce_nx    = (q.ce_s[2] == q.ce_s[1]) ? q.ce_s[1] : q.ce;
    ck_nx    = (q.ck_s[2] == q.ck_s[1]) ? q.ck_s[1] : q.ck;
    si_nx    = q.si_s[2];
    d.ce     = ce_nx;
    d.ck     = ck_nx;

    // ----------------------------------------------------------------
    // edge decode
    // ----------------------------------------------------------------
    ce_rise  = ce_nx & ~q.ce;
    ce_fall  = ~ce_nx & q.ce;
    ck_edge  = q.ce & ce_nx & (ck_nx != q.ck);
    smp      = ck_edge & (ck_nx == q.pol);
    drv      = ck_edge & (ck_nx != q.pol);

    // ----------------------------------------------------------------
    // command fields and buffer strobes
    // ----------------------------------------------------------------
    rd       = q.fmt[2];
    burst    = ~q.fmt[3];
    byte_in  = {q.sh[6:0], si_nx};
    byte_end = smp & (q.cnt == 3'(RTCSP_BYTE_BITS - 1));
    push     = byte_end & (q.ph == RTCSP_DATA) & ~rd;
    pop      = (q.nb != 2'h0) & wr_ready_i;
    push_ok  = push & ((q.nb != 2'h2) | pop);
    entry    = {q.ptr, byte_in};

    // ----------------------------------------------------------------
    // session start and end
    // ----------------------------------------------------------------
    if (ce_rise) begin
      d.pol = ck_nx;
      d.ph  = RTCSP_CMD;
      d.cnt = 3'h0;
      d.sh  = RTCSP_RESET_BYTE;
      d.so  = 1'b0;
    end
    if (ce_fall) begin
      d.ph  = RTCSP_CMD;
      d.cnt = 3'h0;
    end

    // ----------------------------------------------------------------
    // transmit
    // ----------------------------------------------------------------
    if (drv && q.ph == RTCSP_DATA && rd) begin
      d.so = q.tx[7];
      d.tx = {q.tx[6:0], 1'b0};
    end

    // ----------------------------------------------------------------
    // receive
    // ----------------------------------------------------------------
    if (smp) begin
      d.sh  = byte_in;
      d.cnt = q.cnt + 3'h1;
    end
    if (byte_end) begin
      case (q.ph)
        RTCSP_CMD: begin
          d.ptr = byte_in[RTCSP_CMD_ADDR_MSB:RTCSP_CMD_ADDR_LSB];
          d.fmt = byte_in[RTCSP_CMD_FMT_MSB:RTCSP_CMD_FMT_LSB];
          d.ph  = RTCSP_DATA;
          d.tx  = reg_rdata_i;
        end
        RTCSP_DATA: begin
          if (burst) begin
            d.ptr = q.ptr + 4'h1;
          end else begin
            d.ph = RTCSP_CMD;
          end
          if (burst && rd) begin
            d.tx = reg_rdata_i;
          end
        end
        default: begin
          d.ph = RTCSP_CMD;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // two-entry write buffer, a word beyond two is dropped
    // ----------------------------------------------------------------
    if (pop) begin
      d.b0 = q.b1;
    end
    if (push_ok) begin
      if (q.nb == 2'h0 || (q.nb == 2'h1 && pop)) begin
        d.b0 = entry;
      end else begin
        d.b1 = entry;
      end
    end
    case ({push_ok, pop})
      2'b10:   d.nb = q.nb + 2'h1;
      2'b01:   d.nb = q.nb - 2'h1;
      default: d.nb = q.nb;
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // store side
  // ------------------------------------------------------------------
  // next burst byte is fetched from the pointer after increment
  assign reg_addr_o   = (q.ph == RTCSP_DATA && burst) ? q.ptr + 4'h1
                                                      : byte_in[RTCSP_CMD_ADDR_MSB:RTCSP_CMD_ADDR_LSB];
  assign wr_valid_o   = q.nb != 2'h0;
  assign wr_data_o    = q.b0[7:0];
  assign wr_addr_o    = q.b0[11:8];
  // carries are held for the whole session
  assign carry_hold_o = q.ce;

  // ------------------------------------------------------------------
  // link outputs
  // ------------------------------------------------------------------
  assign link.so      = q.so;
  assign link.so_oe_n = ~(q.ce && rd && q.ph == RTCSP_DATA);
endmodule

// file: rtl/rtcsp_host.sv
`timescale 1ns/100ps
module rtcsp_host
  import rtcsp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // link
  rtcsp_if.host           link,
  // user side
  input  wire logic       start_i,
  input  wire logic       pol_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       last_i,
  output logic            tx_ready_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_o,
  output logic            busy_o
);
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_SHIFT, H_GAP} rtcsp_hst_e;
  typedef struct packed {
    rtcsp_hst_e  st;
    logic [15:0] t;
    logic [2:0]  bit_n;
    logic [7:0]  sh, rx;
    logic        ck;
    logic        ce;
    logic        pol;
    logic        last;
    logic        rv;
    logic        ld;
    logic [2:0]  so_s;
  } rtcsp_host_s;
  rtcsp_host_s q;
  rtcsp_host_s d;
  always_comb begin
    d      = q;
    d.rv   = 1'b0;
    d.so_s = {q.so_s[1:0], link.so};
    case (q.st)
      H_IDLE: begin
        if (start_i) begin
          d.st    = H_SETUP;
          d.ce    = 1'b1;
          d.pol   = pol_i;
          d.ck    = pol_i;
          d.t     = 16'(RTCSP_CE_SETUP_CYC);
          d.sh    = tx_i;
          d.last  = last_i;
          d.ld    = 1'b0;
          d.bit_n = 3'h0;
        end
      end
      H_SETUP: begin
        if (q.t == 16'h0) begin
          d.st = H_SHIFT;
        end else begin
          d.t = q.t - 16'h1;
        end
      end
      H_SHIFT: begin
        d.t = q.t + 16'h1;
        if (q.t == 16'(RTCSP_SCLK_DIV - 1)) begin
          d.t  = 16'h0;
          d.ck = ~q.ck;
          if (q.ck != q.pol) begin                          // sample edge
            d.rx    = {q.rx[6:0], q.so_s[2]};
            d.bit_n = q.bit_n + 3'h1;
            if (q.bit_n == 3'h7) begin
              d.rv = 1'b1;
              if (q.last) begin
                // ce drops one half period after the last sample edge
                d.st = H_GAP;
                d.t  = 16'(RTCSP_CE_GAP_CYC + RTCSP_SCLK_DIV);
              end else begin
                d.ld = 1'b1;
              end
            end
          end else if (q.ld) begin                          // drive edge
            d.sh   = tx_i;
            d.last = last_i;
            d.ld   = 1'b0;
          end else if (q.bit_n != 3'h0) begin
            d.sh = {q.sh[6:0], 1'b0};
          end
        end
      end
      H_GAP: begin
        if (q.t == 16'(RTCSP_CE_GAP_CYC)) begin
          d.ce = 1'b0;
        end
        if (q.t == 16'h0) begin
          d.st = H_IDLE;
        end else begin
          d.t = q.t - 16'h1;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign link.ce    = q.ce;
  assign link.sclk  = q.ck;
  assign link.si    = q.sh[7];
  assign tx_ready_o = q.st == H_SHIFT && q.t == 16'(RTCSP_SCLK_DIV - 1)
                      && q.ck == q.pol && q.ld;
  assign rx_valid_o = q.rv;
  assign rx_o       = q.rx;
  assign busy_o     = q.st != H_IDLE;
endmodule

// file: rtl/rtcsp_if.sv
`timescale 1ns/100ps
interface rtcsp_if;
  logic ce;
  logic sclk;
  logic si;
  logic so;
  logic so_oe_n;
  modport dev  (input ce, input sclk, input si, output so, output so_oe_n);
  modport host (output ce, output sclk, output si, input so, input so_oe_n);
endinterface

// file: rtl/rtcsp_pkg.sv
package rtcsp_pkg;
  localparam logic [3:0] RTCSP_FMT_WR_SINGLE = 4'h8;
  localparam logic [3:0] RTCSP_FMT_WR_BURST  = 4'h0;
  localparam logic [3:0] RTCSP_FMT_RD_SINGLE = 4'hc;
  localparam logic [3:0] RTCSP_FMT_RD_BURST  = 4'h4;
  localparam int         RTCSP_CMD_ADDR_MSB  = 7;
  localparam int         RTCSP_CMD_ADDR_LSB  = 4;
  localparam int         RTCSP_CMD_FMT_MSB   = 3;
  localparam int         RTCSP_CMD_FMT_LSB   = 0;
  localparam int         RTCSP_BYTE_BITS     = 8;
  localparam int         RTCSP_CLK_MHZ       = 200;
  localparam int         RTCSP_CE_SETUP_US   = 31;
  localparam int         RTCSP_CE_GAP_US     = 61;
  localparam int         RTCSP_CE_SETUP_CYC  = RTCSP_CE_SETUP_US * RTCSP_CLK_MHZ;
  localparam int         RTCSP_CE_GAP_CYC    = RTCSP_CE_GAP_US * RTCSP_CLK_MHZ;
  localparam int         RTCSP_SCLK_DIV      = 16;
  localparam logic [7:0] RTCSP_RESET_BYTE    = 8'h00;
  typedef enum logic [1:0] {RTCSP_CMD, RTCSP_DATA} rtcsp_phase_e;
endpackage

// file: verif/rtcsp_assertions.sv
`timescale 1ns/100ps
module rtcsp_assertions
  import rtcsp_pkg::*;
(
  // watched link
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  // ----
  // session trackers
  // ----
  logic        pol_q;
  logic [3:0]  edg_q;
  int unsigned up_q;
  int unsigned dn_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pol_q <= 1'b0;
      edg_q <= 4'h0;
      up_q  <= 32'h0;
      dn_q  <= 32'hffff;
    end else begin
      if ($rose(ce)) pol_q <= sclk;
      edg_q <= (ce && $past(ce)) ? edg_q + 4'($changed(sclk)) : 4'h0;
      up_q  <= ce ? up_q + 32'h1 : 32'h0;
      dn_q  <= ce ? 32'h0 : dn_q + 32'(dn_q < 32'hffff);
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_sess;
    $rose(ce) ##1 ce;
  endsequence
  chk_sess_quiet: assert property (s_sess |-> so_oe_n [*8])
    else $error("so driven during command");
  chk_oe_idle: assert property (!ce && !$past(ce, 8) |-> so_oe_n)
    else $error("so driven while idle");
  chk_so_rise_mode: assert property (ce && !pol_q && !so_oe_n && $fell(sclk) |-> so == $past(so, 8))
    else $error("so moved near falling sample");
  chk_so_fall_mode: assert property (ce && pol_q && !so_oe_n && $rose(sclk) |-> so == $past(so, 8))
    else $error("so moved near rising sample");
  chk_si_setup: assert property (ce && $past(ce) && (pol_q ? $rose(sclk) : $fell(sclk)) |-> si == $past(si, 8))
    else $error("si moved near sample");
  chk_ce_setup: assert property (ce && $past(ce) && $changed(sclk) |-> up_q >= RTCSP_CE_SETUP_CYC - 1)
    else $error("sclk too soon after ce");
  chk_ce_gap: assert property ($rose(ce) |-> dn_q >= RTCSP_CE_GAP_CYC - 1)
    else $error("ce low gap too short");
  chk_ce_bytes: assert property ($fell(ce) |-> edg_q == 4'h0)
    else $error("partial byte at ce fall");
  chk_ce_short: assert property (ce |-> up_q < 32'hbebc200)
    else $error("ce high over one second");
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rtcsp_pkg::*;
  logic        core_clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, pol_i = 1'b0;
  logic        last_i = 1'b0, wr_ready_i = 1'b0, tx_ready_o, rx_valid_o, busy_o;
  logic        wr_valid_o, carry_hold_o;
  logic [7:0]  tx_i = 8'h00, reg_rdata_i, rx_o, wr_data_o, mem [16], shd [16];
  logic [3:0]  reg_addr_o, wr_addr_o;
  logic [8:0]  e, rx_q [$];
  logic [11:0] wr_q [$];
  logic [7:0]  tx_seq [$];
  int          failures = 0, checked = 0;
  rtcsp_if lnk ();
  rtcsp_dev u_rtcsp_dev (.core_clk_i, .reset_i, .link(lnk), .reg_addr_o, .reg_rdata_i,
    .wr_valid_o, .wr_ready_i, .wr_data_o, .wr_addr_o, .carry_hold_o);
  rtcsp_host u_rtcsp_host (.core_clk_i, .reset_i, .link(lnk), .start_i, .pol_i, .tx_i,
    .last_i, .tx_ready_o, .rx_valid_o, .rx_o, .busy_o);
  rtcsp_assertions u_rtcsp_assertions (.core_clk_i, .reset_i, .ce(lnk.ce), .sclk(lnk.sclk),
    .si(lnk.si), .so(lnk.so), .so_oe_n(lnk.so_oe_n));
  assign reg_rdata_i = mem[reg_addr_o];
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) #1 wr_ready_i = 1'($urandom);
  // ----
  // tasks
  // ----
  task chk(input string n, input logic [11:0] x, input logic [11:0] s);
    checked++;
    if (x !== s) begin
      failures++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  task put(input logic [1:0] k, input logic [3:0] a, input logic [3:0] f);
    logic [7:0] d;
    d = 8'($urandom);
    case (k)
      2'h0: d = {a, f};
      2'h1: begin
        wr_q.push_back({a, d});
        shd[a] = d;
      end
      default: ;
    endcase
    rx_q.push_back({k == 2'h2, shd[a]});
    tx_seq.push_back(d);
  endtask
  task run(input logic p);
    int   n;
    logic tk;
    @(posedge core_clk_i);
    #1;
    pol_i   = p;
    tx_i    = tx_seq.pop_front();
    last_i  = (tx_seq.size() == 0);
    start_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    start_i = 1'b0;
    tk      = 1'b1;
    for (n = 0; n < 40000 && busy_o !== 1'b0; n++) begin
      if (tk && tx_seq.size() > 0) begin
        tx_i   = tx_seq.pop_front();
        last_i = (tx_seq.size() == 0);
      end
      tk = (tx_ready_o === 1'b1);
      @(posedge core_clk_i);
      #1;
    end
    chk("left", 12'h0, 12'(rx_q.size() + wr_q.size() + tx_seq.size()));
    chk("hold", 12'h0, {11'h0, carry_hold_o});
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // result watcher
  // ----
  always @(negedge core_clk_i) begin
    if (rx_valid_o === 1'b1) begin
      e = rx_q.pop_front();
      chk("hold", 12'h1, {11'h0, carry_hold_o});
      if (e[8]) chk("rx", {4'h0, e[7:0]}, {4'h0, rx_o});
    end
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
      chk("wr", wr_q.pop_front(), {wr_addr_o, wr_data_o});
      mem[wr_addr_o] <= wr_data_o;
    end
  end
  initial begin
    #(90000 * 5);
    failures++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h0a3d4b66));
    foreach (mem[i]) begin
      mem[i] = 8'($urandom);
      shd[i] = mem[i];
    end
    repeat (20) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    put(2'h0, 4'he, RTCSP_FMT_WR_BURST);
    for (int i = 0; i < 3; i++) put(2'h1, 4'he + 4'(i), 4'h0);
    run(1'b0);
    put(2'h0, 4'hf, RTCSP_FMT_RD_BURST);
    for (int i = 0; i < 3; i++) put(2'h2, 4'hf + 4'(i), 4'h0);
    run(1'b1);
    put(2'h0, 4'h3, RTCSP_FMT_WR_SINGLE);
    put(2'h1, 4'h3, 4'h0);
    put(2'h0, 4'h3, RTCSP_FMT_RD_SINGLE);
    put(2'h2, 4'h3, 4'h0);
    put(2'h0, 4'h1, RTCSP_FMT_RD_BURST);
    put(2'h2, 4'h1, 4'h0);
    put(2'h2, 4'h2, 4'h0);
    run(1'b0);
    end_of_test;
  end
endmodule
